// *** logic/dhcp_link.sv ***
`default_nettype none
module dhcp_link
  import dhcp_pkg::*;
(
  input wire logic host_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ext_reset_n,
  input wire logic serial_mode,
  input wire logic four_wire_select,
  input wire logic [1:0] width_sel,
  input wire logic [17:0] data_in,
  input wire logic cmd_data_flag,
  dhcp_link_if.link lk
);
  // Straps are static in use, so they are read here without a synchroniser
  logic frame_rst;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic dc_bit;
  logic rd_req;
  logic [7:0] rd_code;
  logic [7:0] next_sh;
  logic last_bit;
  logic pkt_dc;
  logic [5:0] rd_left;
  logic [31:0] rd_sh;
  logic [31:0] rd_load;

  assign frame_rst = cs_n | ~ext_reset_n | rst;
  assign next_sh = {shreg[6:0], data_in[0]};
  assign last_bit = four_wire_select ? (bit_cnt == BIT_LAST_4W) :
                    (bit_cnt == BIT_LAST_3W);
  assign pkt_dc = four_wire_select ? cmd_data_flag : dc_bit;

  // Partial bits die with the frame
  always_ff @(posedge host_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= BIT_FIRST;
      shreg <= '0;
      dc_bit <= 1'b0;
      rd_req <= 1'b0;
      rd_code <= CMD_RESET;
    end else if (serial_mode && !rd_req) begin
      if (last_bit)
        bit_cnt <= BIT_FIRST;
      else
        bit_cnt <= bit_cnt + 4'h1;
      if (!four_wire_select && bit_cnt == BIT_FIRST)
        dc_bit <= data_in[0];
      else
        shreg <= next_sh;
      if (last_bit && !pkt_dc && read_len(next_sh) != RD_LEN_NONE) begin
        rd_req <= 1'b1;
        rd_code <= next_sh;
      end
    end
  end

  // Reset by system reset only, so the toggle never jumps on a break
  always_ff @(posedge host_clk or posedge rst) begin
    if (rst) begin
      lk.word <= '0;
      lk.dc <= 1'b0;
      lk.tgl <= 1'b0;
    end else if (!cs_n && ext_reset_n) begin
      if (!serial_mode) begin
        lk.word <= data_in & width_mask(width_sel);
        lk.dc <= cmd_data_flag;
        lk.tgl <= ~lk.tgl;
      end else if (last_bit && !rd_req) begin
        lk.word <= {10'h000, next_sh};
        lk.dc <= pkt_dc;
        lk.tgl <= ~lk.tgl;
      end
    end
  end

  always_comb begin
    case (read_len(rd_code))
      RD_LEN_DID: rd_load = {lk.snap_id, 8'h00};
      RD_LEN_DST: rd_load = lk.snap_status;
      default: rd_load = {lk.snap_byte, 24'h000000};
    endcase
  end

  // First answer bit leaves on the falling edge of the last command bit
  always_ff @(negedge host_clk or posedge frame_rst) begin
    if (frame_rst) begin
      rd_sh <= '0;
      rd_left <= RD_LEN_NONE;
      lk.sdo_en <= 1'b0;
    end else if (rd_req && !lk.sdo_en) begin
      rd_sh <= rd_load;
      rd_left <= read_len(rd_code) - 6'h01;
      lk.sdo_en <= 1'b1;
    end else if (lk.sdo_en && rd_left != RD_LEN_NONE) begin
      rd_sh <= {rd_sh[30:0], 1'b0};
      rd_left <= rd_left - 6'h01;
    end
  end

  assign lk.sdo = rd_sh[31];
endmodule
`default_nettype wire

// *** logic/dhcp_link_if.sv ***
`default_nettype none
interface dhcp_link_if;
  logic [17:0] word;
  logic dc;
  logic tgl;
  logic sdo;
  logic sdo_en;
  logic [23:0] snap_id;
  logic [31:0] snap_status;
  logic [7:0] snap_byte;
  modport link (
    output word, dc, tgl, sdo, sdo_en,
    input snap_id, snap_status, snap_byte
  );
  modport core (
    input word, dc, tgl, sdo, sdo_en,
    output snap_id, snap_status, snap_byte
  );
endinterface
`default_nettype wire

// *** logic/dhcp_pkg.sv ***
`default_nettype none
package dhcp_pkg;
  typedef enum logic [1:0] {
    DHCP_W8 = 2'b00,
    DHCP_W16 = 2'b01,
    DHCP_W9 = 2'b10,
    DHCP_W18 = 2'b11
  } dhcp_width_t;

  localparam int DATA_W = 18;
  localparam logic [7:0] MEM_WRITE_CMD = 8'h2c;
  localparam logic [7:0] MEM_READ_CMD = 8'h2e;
  localparam logic [7:0] READ_DISPLAY_ID_CMD = 8'h04;
  localparam logic [7:0] READ_DISPLAY_STATUS_CMD = 8'h09;
  localparam logic [7:0] READ_ID_BYTE1_CMD = 8'hda;
  localparam logic [7:0] READ_ID_BYTE2_CMD = 8'hdb;
  localparam logic [7:0] READ_ID_BYTE3_CMD = 8'hdc;
  localparam logic [7:0] STATUS_READ_FIRST = 8'h0a;
  localparam logic [7:0] STATUS_READ_LAST = 8'h0f;
  localparam logic [5:0] RD_LEN_NONE = 6'h00;
  localparam logic [5:0] RD_LEN_BYTE = 6'h08;
  localparam logic [5:0] RD_LEN_DID = 6'h18;
  localparam logic [5:0] RD_LEN_DST = 6'h20;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST_3W = 4'h8;
  localparam logic [3:0] BIT_LAST_4W = 4'h7;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [1:0] RD_IDX_RESET = 2'h0;

  function automatic logic [17:0] width_mask(input logic [1:0] w);
    case (dhcp_width_t'(w))
      DHCP_W8: width_mask = 18'h000ff;
      DHCP_W16: width_mask = 18'h0ffff;
      DHCP_W9: width_mask = 18'h001ff;
      default: width_mask = 18'h3ffff;
    endcase
  endfunction

  function automatic logic [5:0] read_len(input logic [7:0] c);
    if (c == READ_DISPLAY_ID_CMD)
      read_len = RD_LEN_DID;
    else if (c == READ_DISPLAY_STATUS_CMD)
      read_len = RD_LEN_DST;
    else if (c == READ_ID_BYTE1_CMD || c == READ_ID_BYTE2_CMD ||
             c == READ_ID_BYTE3_CMD ||
             (c >= STATUS_READ_FIRST && c <= STATUS_READ_LAST))
      read_len = RD_LEN_BYTE;
    else
      read_len = RD_LEN_NONE;
  endfunction
endpackage
`default_nettype wire

// *** logic/dhcp_port.sv ***
`default_nettype none
// Function
// - Top strap low picks serial; else low straps pick 8/16/9/18-bit bus.
// - Only the lowest lines of the chosen width are used; upper ignored.
// - Parallel port responds only while chip select is low.
// - Write data and flag are captured on the write strobe rising edge.
// - Flag low is a command; flag high is parameter or RAM data.
// - Commands and parameters always come from the lowest eight lines.
// - ID and status reads return bytes on low eight lines.
// - Read data is driven after read strobe falls; host samples on rise.
// - Strobes are asynchronous and may stop between accesses.
// - Serial select input picks 3-line 9-bit or 4-line 8-bit packets.
// - 3-line packets send flag bit first; 4-line uses the flag pin.
// - Serial bytes go most significant bit first both ways.
// - Chip select high holds serial logic idle; falling edge starts.
// - Serial data on rising clock; flag on first or eighth edge.
// - With chip select still low, next edge starts the next packet.
// - Serial reads return 8, 24 or 32 bits after the read command.
// - Serial read data shifts on falling clock edges.
// - External reset drops partial bits and expects a command next.
// - Chip select release mid byte drops bits; same byte resent.
// - A broken parameter is dropped when a new command follows.
// - New command keeps received parameters; the rest stay untouched.
// - Pause after a whole byte resumes the same sequence later.
module dhcp_port
  import dhcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic host_clk,
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic cmd_data_flag,
  input wire logic ext_reset_n,
  input wire logic iface_sel_top,
  input wire logic iface_sel_mid,
  input wire logic iface_sel_low,
  input wire logic four_wire_select,
  input wire logic [17:0] data_in,
  output logic [17:0] data_out,
  output logic data_oe,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic param_valid,
  output logic [7:0] param_data,
  output logic [7:0] param_index,
  output logic ram_wr_valid,
  output logic [17:0] ram_wr_data,
  output logic ram_rd_next,
  input wire logic [17:0] ram_rd_data,
  input wire logic [23:0] id_word,
  input wire logic [31:0] status_word,
  input wire logic [7:0] reg_byte
);
  dhcp_link_if lk ();

  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic rd_s3;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic ext_ok;
  logic cs_idle;
  logic rd_rise;
  logic serial_s;
  logic [1:0] width_s;
  logic evt;
  logic mem_wr;
  logic [7:0] next_index;
  logic [7:0] rd_code;
  logic rd_mem;
  logic [1:0] rd_idx;
  logic [17:0] par_out;
  logic [7:0] rd_byte;
  logic [17:0] mask_s;
  logic after_cmd;

  dhcp_link u_link (
    .host_clk(host_clk),
    .rst(rst),
    .cs_n(cs_n),
    .ext_reset_n(ext_reset_n),
    .serial_mode(~iface_sel_top),
    .four_wire_select(four_wire_select),
    .width_sel({iface_sel_mid, iface_sel_low}),
    .data_in(data_in),
    .cmd_data_flag(cmd_data_flag),
    .lk(lk)
  );

  // Pin synchronisers; logic reads the second stage, and a third for the read strobe edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1 <= 7'h7f;
      pin_s2 <= 7'h7f;
      rd_s3 <= 1'b1;
    end else if (ce) begin
      pin_s1 <= {ext_reset_n, cs_n, read_strobe_n, iface_sel_top,
                 iface_sel_mid, iface_sel_low, four_wire_select};
      pin_s2 <= pin_s1;
      rd_s3 <= pin_s2[4];
    end
  end

  assign ext_ok = pin_s2[6];
  assign cs_idle = pin_s2[5];
  assign rd_rise = pin_s2[4] & ~rd_s3;
  assign serial_s = ~pin_s2[3];
  assign width_s = pin_s2[2:1];
  assign mask_s = width_mask(width_s);

  // Toggle crossing: the link holds its word for several system cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (ce) begin
      tgl_s1 <= lk.tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign evt = tgl_s2 ^ tgl_s3;

  // Snapshots change only while the host is idle, so the link sees them still
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lk.snap_id <= '0;
      lk.snap_status <= '0;
      lk.snap_byte <= '0;
    end else if (ce && cs_idle) begin
      lk.snap_id <= id_word;
      lk.snap_status <= status_word;
      lk.snap_byte <= reg_byte;
    end
  end

  // Byte decode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= CMD_RESET;
      param_valid <= 1'b0;
      param_data <= '0;
      param_index <= INDEX_RESET;
      ram_wr_valid <= 1'b0;
      ram_wr_data <= '0;
      mem_wr <= 1'b0;
      next_index <= INDEX_RESET;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      param_valid <= 1'b0;
      ram_wr_valid <= 1'b0;
      if (!ext_ok) begin
        mem_wr <= 1'b0;
        next_index <= INDEX_RESET;
        param_index <= INDEX_RESET;
      end else if (evt) begin
        if (!lk.dc) begin
          cmd_valid <= 1'b1;
          cmd_code <= lk.word[7:0];
          mem_wr <= (lk.word[7:0] == MEM_WRITE_CMD);
          next_index <= INDEX_RESET;
        end else if (mem_wr) begin
          ram_wr_valid <= 1'b1;
          ram_wr_data <= lk.word & mask_s;
        end else begin
          param_valid <= 1'b1;
          param_data <= lk.word[7:0];
          param_index <= next_index;
          next_index <= next_index + 8'h01;
        end
      end
    end
  end

  // Parallel read-back state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_code <= CMD_RESET;
      rd_mem <= 1'b0;
      rd_idx <= RD_IDX_RESET;
      ram_rd_next <= 1'b0;
    end else if (ce) begin
      ram_rd_next <= 1'b0;
      if (!ext_ok) begin
        rd_code <= CMD_RESET;
        rd_mem <= 1'b0;
        rd_idx <= RD_IDX_RESET;
      end else if (evt && !lk.dc) begin
        rd_code <= lk.word[7:0];
        rd_mem <= (lk.word[7:0] == MEM_READ_CMD);
        rd_idx <= RD_IDX_RESET;
      end else if (rd_rise && !serial_s && !cs_idle) begin
        ram_rd_next <= rd_mem;
        rd_idx <= rd_idx + 2'h1;
      end
    end
  end

  always_comb begin
    case (read_len(rd_code))
      RD_LEN_DID: begin
        case (rd_idx)
          2'h0: rd_byte = id_word[23:16];
          2'h1: rd_byte = id_word[15:8];
          default: rd_byte = id_word[7:0];
        endcase
      end
      RD_LEN_DST: begin
        case (rd_idx)
          2'h0: rd_byte = status_word[31:24];
          2'h1: rd_byte = status_word[23:16];
          2'h2: rd_byte = status_word[15:8];
          default: rd_byte = status_word[7:0];
        endcase
      end
      default: rd_byte = reg_byte;
    endcase
  end

  // Pixel reads use the full width, ID and status the low byte only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      par_out <= '0;
    else if (ce) begin
      if (rd_mem)
        par_out <= ram_rd_data & mask_s;
      else
        par_out <= {10'h000, rd_byte};
    end
  end

  // Parallel bus turn-around straight from the pins; serial enable is sdo_en from the link
  always_comb begin
    if (!iface_sel_top) begin
      data_out = {17'h00000, lk.sdo};
      data_oe = lk.sdo_en;
    end else begin
      data_out = par_out;
      data_oe = ~cs_n & ~read_strobe_n;
    end
  end

  // Assertion helper: next data byte is the first after a command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      after_cmd <= 1'b0;
    else if (ce && ext_ok && evt)
      after_cmd <= !lk.dc;
  end

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_cmd_byte;
    ce && ext_ok && evt && !lk.dc;
  endsequence

  sequence s_data_byte;
    ce && ext_ok && evt && lk.dc;
  endsequence

  property p_cmd_taken;
    s_cmd_byte |=> cmd_valid && cmd_code == $past(lk.word[7:0]);
  endproperty
  a_cmd_taken: assert property (p_cmd_taken)
    else $error("command byte not reported");

  property p_param_low_byte;
    s_data_byte ##0 !mem_wr |=>
      param_valid && param_data == $past(lk.word[7:0]) && !ram_wr_valid;
  endproperty
  a_param_low_byte: assert property (p_param_low_byte)
    else $error("parameter not taken from low byte");

  property p_ram_full_width;
    s_data_byte ##0 mem_wr |=>
      ram_wr_valid && ram_wr_data == ($past(lk.word) & $past(mask_s));
  endproperty
  a_ram_full_width: assert property (p_ram_full_width)
    else $error("memory write data lost");

  property p_width_mask;
    ram_wr_valid |-> (ram_wr_data & ~mask_s) == 18'h00000;
  endproperty
  a_width_mask: assert property (p_width_mask)
    else $error("upper data lines leaked");

  property p_ext_reset;
    ce && !ext_ok |=> !cmd_valid && !param_valid && !ram_wr_valid &&
      next_index == INDEX_RESET && !mem_wr;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset left decode state");

  property p_cmd_restarts;
    s_data_byte ##0 !mem_wr && after_cmd |=>
      param_valid && param_index == INDEX_RESET;
  endproperty
  a_cmd_restarts: assert property (p_cmd_restarts)
    else $error("first parameter index wrong");

  property p_pause_resumes;
    ce && ext_ok && !evt && $rose(cs_idle) |=> $stable(next_index);
  endproperty
  a_pause_resumes: assert property (p_pause_resumes)
    else $error("pause disturbed parameter position");

  property p_one_event;
    ce && evt |=> !ce || !evt;
  endproperty
  a_one_event: assert property (p_one_event)
    else $error("handshake event repeated");

  property p_id_low_byte;
    ce && !rd_mem |=> par_out[17:8] == 10'h000;
  endproperty
  a_id_low_byte: assert property (p_id_low_byte)
    else $error("status read drove upper lines");

  property p_serial_idle;
    ce && $past(ce) && $past(ce, 2) && cs_idle |-> !lk.sdo_en;
  endproperty
  a_serial_idle: assert property (p_serial_idle)
    else $error("serial output driven while deselected");

  property p_rd_next;
    ce && ext_ok && !evt && rd_rise && !serial_s && !cs_idle |=>
      ram_rd_next == $past(rd_mem);
  endproperty
  a_rd_next: assert property (p_rd_next)
    else $error("pixel read advance wrong");

  property p_oe_needs_cs;
    iface_sel_top && data_oe |-> !cs_n && !read_strobe_n;
  endproperty
  a_oe_needs_cs: assert property (p_oe_needs_cs)
    else $error("bus driven without chip select");
endmodule
`default_nettype wire

// *** verif/dhcp_host.sv ***
`default_nettype none
module dhcp_host (
  output logic host_clk,
  output logic cs_n,
  output logic read_strobe_n,
  output logic cmd_data_flag,
  output logic [17:0] data_in,
  input wire logic [17:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_clk = 1'b0;
    cs_n = 1'b1;
    read_strobe_n = 1'b1;
    cmd_data_flag = 1'b0;
    data_in = 18'h00000;
  end

  // Serial clock only runs inside frames; n below full width breaks a byte
  task automatic ser(input logic dc, input logic [7:0] b, input logic fw,
                     input int n);
    logic [8:0] v;
    v = fw ? {b, 1'b0} : {dc, b};
    cmd_data_flag <= dc;
    cs_n <= 1'b0;
    #20;
    for (int i = 8; i > 8 - n; i--) begin
      data_in[0] <= v[i];
      #15 host_clk <= 1'b1;
      #15 host_clk <= 1'b0;
    end
  endtask

  task automatic sread(input int n, output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      data_in[0] <= ~data_in[0];
      #15 v = {v[30:0], data_out[0]};
      host_clk <= 1'b1;
      #15 host_clk <= 1'b0;
    end
  endtask

  task automatic cs_off;
    #20 cs_n <= 1'b1;
    data_in <= ~data_in;
    #60;
  endtask

  task automatic pw(input logic dc, input logic [17:0] d, input logic sel);
    cmd_data_flag <= dc;
    data_in <= d;
    cs_n <= ~sel;
    host_clk <= 1'b0;
    #40 host_clk <= 1'b1;
    #80 data_in <= ~d;
  endtask

  task automatic pr(output logic [17:0] v);
    cmd_data_flag <= 1'b1;
    cs_n <= 1'b0;
    read_strobe_n <= 1'b0;
    #150 v = data_out;
    read_strobe_n <= 1'b1;
    #120;
  endtask
endmodule
`default_nettype wire

// *** verif/dhcp_port_bench.sv ***
`default_nettype none
module dhcp_port_bench;
  import dhcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, ext_reset_n, top, mid, low, fws;
  logic host_clk, cs_n, rd_n, dcf, data_oe;
  logic [17:0] din, dout, ram_wr_data, ram_rd_data, mask, e, seen, v18;
  logic cmd_valid, param_valid, ram_wr_valid, ram_rd_next, ce;
  logic [7:0] cmd_code, param_data, param_index, reg_byte, last_cmd, pidx, ix;
  logic [23:0] id_word;
  logic [31:0] status_word, v;
  logic [1:0] k;
  logic [1:0] kq[$];
  logic [17:0] vq[$];
  logic [7:0] iq[$];
  int n_mismatch, comparisons, n_rd_next;

  dhcp_host hc (.host_clk(host_clk), .cs_n(cs_n), .read_strobe_n(rd_n),
    .cmd_data_flag(dcf), .data_in(din), .data_out(dout));

  dhcp_port uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .host_clk(host_clk), .cs_n(cs_n), .read_strobe_n(rd_n),
    .cmd_data_flag(dcf), .ext_reset_n(ext_reset_n), .iface_sel_top(top),
    .iface_sel_mid(mid), .iface_sel_low(low), .four_wire_select(fws),
    .data_in(din), .data_out(dout), .data_oe(data_oe),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_valid(param_valid),
    .param_data(param_data), .param_index(param_index),
    .ram_wr_valid(ram_wr_valid), .ram_wr_data(ram_wr_data),
    .ram_rd_next(ram_rd_next),
    .ram_rd_data(ram_rd_data), .id_word(id_word),
    .status_word(status_word), .reg_byte(reg_byte));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] x,
                       input string msg);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, s, x);
    end
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reference decoder: command resets index, data after 2Ch goes to RAM
  task automatic expect_byte(input logic dc, input logic [17:0] d);
    if (!dc) begin
      kq.push_back(2'b00);
      vq.push_back({10'h000, d[7:0]});
      iq.push_back(8'h00);
      last_cmd = d[7:0];
      pidx = 8'h00;
    end else if (last_cmd == MEM_WRITE_CMD) begin
      kq.push_back(2'b01);
      vq.push_back(d & mask);
      iq.push_back(8'h00);
    end else begin
      kq.push_back(2'b10);
      vq.push_back({10'h000, d[7:0]});
      iq.push_back(pidx);
      pidx++;
    end
  endtask

  // Pulses frozen by a low enable are counted once, when released
  always @(posedge clk_sys) begin
    if (ce && ram_rd_next)
      n_rd_next++;
    if (ce && (cmd_valid || param_valid || ram_wr_valid)) begin
      if (kq.size() == 0) begin
        check(32'h1, 32'h0, "unexpected byte");
      end else begin
        k = kq.pop_front();
        e = vq.pop_front();
        ix = iq.pop_front();
        seen = ram_wr_valid ? ram_wr_data :
               param_valid ? {10'h000, param_data} : {10'h000, cmd_code};
        check({30'h0, param_valid, ram_wr_valid}, {30'h0, k}, "kind");
        check({14'h0, seen}, {14'h0, e}, "byte");
        if (param_valid) begin
          check({24'h0, param_index}, {24'h0, ix}, "index");
        end
      end
    end
  end

  always @(negedge rd_n) begin
    #100;
    check({31'h0, data_oe}, 32'h1, "read drive");
  end

  task automatic reset_dut;
    @(posedge clk_sys) rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    last_cmd = 8'h00;
    pidx = 8'h00;
  endtask

  task automatic send(input logic dc, input logic [7:0] b, input logic fw);
    expect_byte(dc, {10'h000, b});
    hc.ser(dc, b, fw, fw ? 8 : 9);
  endtask

  task automatic pw(input logic dc, input logic [7:0] lo, input logic rnd);
    logic [17:0] d;
    d = 18'($urandom());
    if (!rnd) d[7:0] = lo;
    expect_byte(dc, d);
    hc.pw(dc, d, 1'b1);
  endtask

  logic [7:0] rc[3] = '{READ_ID_BYTE1_CMD, READ_DISPLAY_ID_CMD,
                        READ_DISPLAY_STATUS_CMD};
  int rn[3] = '{8, 24, 32};

  initial begin
    logic [7:0] b;
    n_mismatch = 0;
    comparisons = 0;
    n_rd_next = 0;
    ce = 1'b1;
    rst = 1'b1;
    ext_reset_n = 1'b1;
    {top, mid, low, fws} = 4'h0;
    mask = 18'h000ff;
    void'($urandom(32'he8f020fd));
    id_word = 24'($urandom());
    status_word = $urandom();
    reg_byte = 8'($urandom());
    ram_rd_data = 18'($urandom());
    reset_dut();
    send(0, 8'hb1, 0);
    send(1, 8'($urandom()), 0);
    send(1, 8'($urandom()), 0);
    @(posedge clk_sys) ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    hc.cs_off();
    // Broken byte is dropped and resent; index carries on after pause
    b = 8'($urandom());
    hc.ser(1, b, 0, 5);
    hc.cs_off();
    send(1, b, 0);
    hc.cs_off();
    hc.ser(1, 8'($urandom()), 0, 4);
    @(posedge clk_sys) ext_reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    hc.cs_off();
    last_cmd = 8'h00;
    send(0, 8'hb4, 0);
    send(1, 8'($urandom()), 0);
    hc.cs_off();
    fws <= 1'b1;
    reset_dut();
    send(0, 8'hb4, 1);
    send(1, 8'($urandom()), 1);
    send(0, 8'hb1, 1);
    send(1, 8'($urandom()), 1);
    hc.cs_off();
    for (int i = 0; i < 3; i++) begin
      send(0, rc[i], 1);
      hc.sread(rn[i], v);
      check({31'h0, data_oe}, 32'h1, "serial drive");
      hc.cs_off();
      check({31'h0, data_oe}, 32'h0, "serial release");
      check(v, i == 0 ? {24'h0, reg_byte} : i == 1 ? {8'h0, id_word} :
            status_word, "serial read");
    end
    top <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      {mid, low} <= 2'(w);
      reset_dut();
      mask = w == 0 ? 18'h000ff : w == 1 ? 18'h0ffff :
             w == 2 ? 18'h001ff : 18'h3ffff;
      pw(0, MEM_WRITE_CMD, 0);
      pw(1, 8'h00, 1);
      pw(1, 8'h00, 1);
      pw(0, 8'hb4, 0);
      pw(1, 8'($urandom()), 0);
      hc.pw(0, 18'h000b1, 1'b0);
    end
    pw(0, READ_DISPLAY_ID_CMD, 0);
    for (int i = 0; i < 3; i++) begin
      hc.pr(v18);
      check({24'h0, v18[7:0]}, {24'h0, 8'(id_word >> (16 - 8 * i))},
            "parallel read");
      check({31'h0, data_oe}, 32'h0, "read release");
    end
    pw(0, MEM_READ_CMD, 0);
    @(posedge clk_sys) ram_rd_data <= 18'($urandom());
    hc.pr(v18);
    check({14'h0, v18}, {14'h0, ram_rd_data & mask}, "pixel read");
    check({31'h0, data_oe}, 32'h0, "read release");
    #2000;
    check(kq.size(), 32'h0, "missing bytes");
    check(n_rd_next, 32'h1, "pixel read advance");
    end_of_test();
  end

  // Whole run takes some 14 us
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
